// *** hdl/shift_transfer_defs.svh ***
// offsets, field positions and reset values of the shift and transfer unit
`ifndef SHIFT_TRANSFER_DEFS_SVH
`define SHIFT_TRANSFER_DEFS_SVH

`define WORD_W 24
`define DOUBLE_W 48
`define APB_ADDR_W 8

`define OFF_CMD 8'h00
`define OFF_INSTR 8'h04
`define OFF_EMA 8'h08
`define OFF_FINAL_IDX 8'h0c
`define OFF_STATUS 8'h10
`define OFF_COND 8'h14
`define OFF_GPR_BASE 8'h18
`define OFF_GPR_LAST 8'h2c

`define GPR_COUNT 6
`define GPR_I 3'd0
`define GPR_J 3'd1
`define GPR_K 3'd2
`define GPR_E 3'd3
`define GPR_A 3'd4
`define GPR_T 3'd5

`define CMD_OP_W 4
`define COUNT_MSB 7
`define COUNT_LSB 0
`define DST_SEL_LSB 0
`define SRC_SEL_LSB 6
`define SEL_W 6
`define XSEL_LSB 12
`define LANE_MSB 23
`define LANE_LSB 22
`define INDEX_LOW_W 16

`define COND_OVF 0
`define COND_NEG 1
`define COND_ZERO 2
`define COND_POS 3
`define COND_RESET 4'h0

`define LANE_HIGH 2'b01
`define LANE_MID 2'b10
`define LANE_LOW 2'b11
`define LANE_NONE 2'b00

`endif

// *** hdl/shift_transfer_exec_unit.sv ***
// shift and transfer execution unit with apb register access and memory port
// Function
// (RULE1) double logical right shift fills zeros
// (RULE2) single right rotate of accumulator
// (RULE3) double rotate crosses E0/A23, A0/E23
// (RULE4) shifts and byte extract set condition
// (RULE5) count from low eight bits, any value
// (RULE6) transfers keep the source register
// (RULE7) transfers set condition from destination
// (RULE8) extract address adds index J low bits
// (RULE9) extract lane from J bits 23:22
// (RULE10) extract final index added algebraically first
// (RULE11) swap memory with index register 1-3
// (RULE12) immediate index swap must not be indexed
// (RULE13) swap memory with accumulator
// (RULE14) swap memory with extension register
// (RULE15) register swap, condition from destination
// (RULE16) one-hot selects, ORed, copied to all
// (RULE17) replace address adds index I
// (RULE18) replace lane from I bits; 00 no-op
// (RULE19) replace final index ORed with I
// (RULE20) byte load into low accumulator byte
// (RULE21) double load E then A from next
// (RULE22) condition bits: ovf,neg,zero,pos
// (RULE23) extract writes only accumulator low byte
// (RULE24) exactly one of pos, neg, zero
//
// The address map and the APB register port were left to the implementer.
`include "shift_transfer_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module shift_transfer_exec_unit
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output shift_transfer_pkg::mem_req_t mem_out,
	input wire shift_transfer_pkg::mem_rsp_t mem_in,
	output logic busy
);
	import shift_transfer_pkg::*;

	unit_state_t s_reg;
	unit_state_t s_next;

	// keeps the overflow flag, sets exactly one of the other three
	function automatic logic [3:0] cond_of(input logic [3:0] old, input logic neg, input logic zero);
		logic [3:0] c;
		c = 4'h0;
		c[`COND_OVF] = old[`COND_OVF]; // [RULE22]
		c[`COND_NEG] = neg;
		c[`COND_ZERO] = zero;
		c[`COND_POS] = !neg && !zero; // [RULE24]
		return c;
	endfunction

	function automatic logic [3:0] cond_word(input logic [3:0] old, input logic [23:0] v);
		return cond_of(old, v[23], v == 24'h000000); // [RULE24]
	endfunction

	function automatic logic [3:0] cond_byte(input logic [3:0] old, input logic [7:0] v);
		return cond_of(old, v[7], v == 8'h00);
	endfunction

	function automatic logic [7:0] pick_lane(input logic [1:0] code, input logic [23:0] w);
		case (code)
			`LANE_HIGH: return w[23:16];
			`LANE_MID: return w[15:8];
			default: return w[7:0]; // both 11 and 00 take the low byte
		endcase
	endfunction

	function automatic logic [23:0] put_lane(input logic [1:0] code, input logic [23:0] w, input logic [7:0] b);
		logic [23:0] r;
		r = w;
		case (code)
			`LANE_HIGH: r[23:16] = b;
			`LANE_MID: r[15:8] = b;
			`LANE_LOW: r[7:0] = b;
			default: r = w;
		endcase
		return r;
	endfunction

	// only aligned words inside the register window reach a register
	function automatic logic gpr_hit(input logic [7:0] a);
		return a >= `OFF_GPR_BASE && a <= `OFF_GPR_LAST && a[1:0] == 2'b00;
	endfunction

	function automatic logic [2:0] gpr_slot(input logic [7:0] a);
		logic [7:0] o;
		o = a - `OFF_GPR_BASE;
		return o[4:2];
	endfunction

	// index field 1, 2, 3 names I, J, K in slots 0 to 2
	function automatic logic [2:0] index_slot(input logic [1:0] x);
		logic [1:0] s;
		s = x - 2'd1;
		return {1'b0, s};
	endfunction

	// full 8-bit count; counts past the width are folded or clear the value
	function automatic logic [47:0] shift_exec(input op_t op, input logic [7:0] n, input logic [47:0] d);
		logic [95:0] dd;
		logic [47:0] aa;
		logic [47:0] r;
		dd = {d, d};
		aa = {d[23:0], d[23:0]};
		r = d;
		case (op)
			OP_LOGICAL_DOUBLE_RIGHT_SHIFT: r = (n >= 8'd48) ? 48'h0 : (d >> n); // [RULE1] [RULE5]
			OP_SINGLE_RIGHT_ROTATE: r = {d[47:24], 24'((aa >> (n % 8'd24)))}; // [RULE2] [RULE5]
			OP_DOUBLE_RIGHT_ROTATE: r = 48'((dd >> (n % 8'd48))); // [RULE3] [RULE5]
			default: r = d;
		endcase
		return r;
	endfunction

	logic [47:0] shifted;
	logic [23:0] src_or;
	logic [23:0] dst_or;
	logic [23:0] fidx_val;
	logic [23:0] emb_addr;
	logic [23:0] rbm_addr;
	logic [5:0] src_sel;
	logic [5:0] dst_sel;
	logic [1:0] xsel;
	logic apb_setup;
	logic apb_write;
	logic [1:0] lane_i;
	logic [1:0] lane_j;

	assign src_sel = s_reg.instr[`SRC_SEL_LSB +: `SEL_W];
	assign dst_sel = s_reg.instr[`DST_SEL_LSB +: `SEL_W];
	assign xsel = s_reg.instr[`XSEL_LSB +: 2];
	// lane codes ride in the top bits of I and J, above the address part
	assign lane_i = s_reg.gpr[`GPR_I][`LANE_MSB:`LANE_LSB];
	assign lane_j = s_reg.gpr[`GPR_J][`LANE_MSB:`LANE_LSB];
	assign shifted = shift_exec(s_reg.op, s_reg.instr[`COUNT_MSB:`COUNT_LSB],
		{s_reg.gpr[`GPR_E], s_reg.gpr[`GPR_A]});
	assign fidx_val = (s_reg.final_idx == 2'd0) ? 24'h000000 : s_reg.gpr[index_slot(s_reg.final_idx)];
	// the final index is a full signed add, J contributes only its low bits
	assign emb_addr = s_reg.effective_memory_address + fidx_val + {8'h00, s_reg.gpr[`GPR_J][15:0]}; // [RULE8] [RULE10]
	// lane code lives in I's top bits, so only the low part reaches the adder
	assign rbm_addr = s_reg.effective_memory_address + ((fidx_val | s_reg.gpr[`GPR_I]) & 24'h00ffff); // [RULE17] [RULE19]

	always_comb
	begin
		src_or = 24'h000000;
		dst_or = 24'h000000;
		for (int i = 0; i < `GPR_COUNT; i++)
		begin
			if (src_sel[i])
				src_or = src_or | s_reg.gpr[i]; // [RULE16]
			if (dst_sel[i])
				dst_or = dst_or | s_reg.gpr[i]; // [RULE16]
		end
	end

	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pwrite && !s_reg.slverr;

	always_comb
	begin
		logic [7:0] lane_b;
		lane_b = 8'h00;
		s_next = s_reg;
		// read data and error are caught in the setup phase so the access needs no wait
		if (apb_setup)
		begin
			s_next.slverr = (paddr > `OFF_GPR_LAST) || (paddr[1:0] != 2'b00);
			s_next.prdata = 32'h00000000;
			case (paddr)
				`OFF_CMD: s_next.prdata = {28'h0, s_reg.op};
				`OFF_INSTR: s_next.prdata = {8'h00, s_reg.instr};
				`OFF_EMA: s_next.prdata = {8'h00, s_reg.effective_memory_address};
				`OFF_FINAL_IDX: s_next.prdata = {30'h0, s_reg.final_idx};
				`OFF_STATUS: s_next.prdata = {31'h0, s_reg.phase != ST_IDLE};
				`OFF_COND: s_next.prdata = {28'h0, s_reg.cond};
				default:
				begin
					if (gpr_hit(paddr))
						s_next.prdata = {8'h00, s_reg.gpr[gpr_slot(paddr)]};
				end
			endcase
		end
		// writes are dropped while an instruction runs
		if (apb_write && s_reg.phase == ST_IDLE)
		begin
			case (paddr)
				`OFF_CMD:
				begin
					s_next.op = op_t'(pwdata[`CMD_OP_W - 1:0]);
					s_next.phase = ST_EXEC;
				end
				`OFF_INSTR: s_next.instr = pwdata[23:0];
				`OFF_EMA: s_next.effective_memory_address = pwdata[23:0];
				`OFF_FINAL_IDX: s_next.final_idx = pwdata[1:0];
				`OFF_COND: s_next.cond = pwdata[3:0];
				default:
				begin
					if (gpr_hit(paddr))
						s_next.gpr[gpr_slot(paddr)] = pwdata[23:0];
				end
			endcase
		end
		case (s_reg.phase)
			ST_IDLE: s_next.mem.req = 1'b0;
			ST_EXEC:
			begin
				s_next.phase = ST_IDLE;
				case (s_reg.op)
					OP_LOGICAL_DOUBLE_RIGHT_SHIFT, OP_DOUBLE_RIGHT_ROTATE:
					begin
						s_next.gpr[`GPR_E] = shifted[47:24];
						s_next.gpr[`GPR_A] = shifted[23:0];
						s_next.cond = cond_of(s_reg.cond, shifted[47], shifted == 48'h0); // [RULE4]
					end
					OP_SINGLE_RIGHT_ROTATE:
					begin
						s_next.gpr[`GPR_A] = shifted[23:0];
						s_next.cond = cond_word(s_reg.cond, shifted[23:0]); // [RULE4]
					end
					OP_REGISTER_SWAP:
					begin
						for (int i = 0; i < `GPR_COUNT; i++)
						begin
							if (src_sel[i])
								s_next.gpr[i] = dst_or; // [RULE15] [RULE16]
						end
						for (int i = 0; i < `GPR_COUNT; i++)
						begin
							if (dst_sel[i])
								s_next.gpr[i] = src_or; // [RULE15] [RULE16]
						end
						s_next.cond = cond_word(s_reg.cond, src_or); // [RULE15]
					end
					OP_BYTE_EXTRACT:
					begin
						s_next.mem = '{req: 1'b1, we: 1'b0, addr: emb_addr, wdata: 24'h000000}; // [RULE8]
						s_next.phase = ST_READ;
					end
					OP_BYTE_REPLACE:
					begin
						// a lane code of 00 makes no memory access at all
						if (lane_i != `LANE_NONE) // [RULE18]
						begin
							s_next.mem = '{req: 1'b1, we: 1'b0, addr: rbm_addr, wdata: 24'h000000}; // [RULE17]
							s_next.phase = ST_READ;
						end
					end
					OP_MEMORY_INDEX_SWAP, OP_MEMORY_ACCUMULATOR_SWAP, OP_MEMORY_EXTENSION_SWAP,
					OP_MEMORY_TO_BYTE_LOAD, OP_MEMORY_TO_DOUBLE_LOAD:
					begin
						// index field 0 names no register, so the swap is skipped
						if (s_reg.op != OP_MEMORY_INDEX_SWAP || xsel != 2'd0) // [RULE11]
						begin
							s_next.mem = '{req: 1'b1, we: 1'b0, addr: s_reg.effective_memory_address, wdata: 24'h000000};
							s_next.phase = ST_READ;
						end
					end
					default: s_next.phase = ST_IDLE;
				endcase
			end
			ST_READ:
			begin
				if (mem_in.ack)
				begin
					s_next.mem.req = 1'b0;
					s_next.phase = ST_IDLE;
					case (s_reg.op)
						OP_BYTE_EXTRACT:
						begin
							lane_b = pick_lane(lane_j, mem_in.rdata); // [RULE9]
							s_next.gpr[`GPR_A][7:0] = lane_b; // [RULE23]
							s_next.cond = cond_byte(s_reg.cond, lane_b); // [RULE4] [RULE7]
						end
						OP_BYTE_REPLACE:
						begin
							s_next.mem.req = 1'b1;
							s_next.mem.we = 1'b1;
							s_next.mem.wdata = put_lane(lane_i, mem_in.rdata,
								s_reg.gpr[`GPR_A][7:0]); // [RULE18] [RULE6]
							s_next.cond = cond_word(s_reg.cond, s_next.mem.wdata); // [RULE7]
							s_next.phase = ST_WRITE;
						end
						OP_MEMORY_INDEX_SWAP:
						begin
							s_next.mem = '{req: 1'b1, we: 1'b1, addr: s_reg.mem.addr, wdata: s_reg.gpr[index_slot(xsel)]};
							s_next.gpr[index_slot(xsel)] = mem_in.rdata; // [RULE11]
							s_next.cond = cond_word(s_reg.cond, mem_in.rdata); // [RULE11]
							s_next.phase = ST_WRITE;
						end
						OP_MEMORY_ACCUMULATOR_SWAP:
						begin
							s_next.mem = '{req: 1'b1, we: 1'b1, addr: s_reg.mem.addr, wdata: s_reg.gpr[`GPR_A]};
							s_next.gpr[`GPR_A] = mem_in.rdata; // [RULE13]
							s_next.cond = cond_word(s_reg.cond, mem_in.rdata); // [RULE13]
							s_next.phase = ST_WRITE;
						end
						OP_MEMORY_EXTENSION_SWAP:
						begin
							s_next.mem = '{req: 1'b1, we: 1'b1, addr: s_reg.mem.addr, wdata: s_reg.gpr[`GPR_E]};
							s_next.gpr[`GPR_E] = mem_in.rdata; // [RULE14]
							s_next.cond = cond_word(s_reg.cond, mem_in.rdata); // [RULE14]
							s_next.phase = ST_WRITE;
						end
						OP_MEMORY_TO_BYTE_LOAD:
						begin
							s_next.gpr[`GPR_A][7:0] = mem_in.rdata[7:0]; // [RULE20]
							s_next.cond = cond_byte(s_reg.cond, mem_in.rdata[7:0]); // [RULE20] [RULE7]
						end
						OP_MEMORY_TO_DOUBLE_LOAD:
						begin
							s_next.gpr[`GPR_E] = mem_in.rdata; // [RULE21]
							s_next.mem.req = 1'b1;
							s_next.mem.addr = s_reg.mem.addr + 24'h000001; // [RULE21]
							s_next.phase = ST_READ2;
						end
						default: s_next.phase = ST_IDLE;
					endcase
				end
			end
			ST_READ2:
			begin
				if (mem_in.ack)
				begin
					s_next.mem.req = 1'b0;
					s_next.gpr[`GPR_A] = mem_in.rdata; // [RULE21]
					s_next.cond = cond_of(s_reg.cond, s_reg.gpr[`GPR_E][23],
						{s_reg.gpr[`GPR_E], mem_in.rdata} == 48'h0); // [RULE21] [RULE7]
					s_next.phase = ST_IDLE;
				end
			end
			ST_WRITE:
			begin
				if (mem_in.ack)
				begin
					s_next.mem.req = 1'b0;
					s_next.mem.we = 1'b0;
					s_next.phase = ST_IDLE;
				end
			end
			default: s_next.phase = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_reg <= '{phase: ST_IDLE, op: OP_NONE, instr: 24'h000000, effective_memory_address: 24'h000000, final_idx: 2'b00,
				gpr: '0, cond: `COND_RESET, mem: '0, prdata: 32'h00000000, slverr: 1'b0};
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && s_reg.slverr;
	assign mem_out = s_reg.mem;
	assign busy = s_reg.phase != ST_IDLE;
endmodule
`default_nettype wire

// *** hdl/shift_transfer_pkg.sv ***
// types of the shift and transfer unit
package shift_transfer_pkg;
	typedef enum logic [3:0] {
		OP_NONE,
		OP_LOGICAL_DOUBLE_RIGHT_SHIFT,
		OP_SINGLE_RIGHT_ROTATE,
		OP_DOUBLE_RIGHT_ROTATE,
		OP_BYTE_EXTRACT,
		OP_MEMORY_INDEX_SWAP,
		OP_MEMORY_ACCUMULATOR_SWAP,
		OP_MEMORY_EXTENSION_SWAP,
		OP_REGISTER_SWAP,
		OP_BYTE_REPLACE,
		OP_MEMORY_TO_BYTE_LOAD,
		OP_MEMORY_TO_DOUBLE_LOAD
	} op_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_EXEC,
		ST_READ,
		ST_READ2,
		ST_WRITE
	} phase_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [23:0] addr;
		logic [23:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic ack;
		logic [23:0] rdata;
	} mem_rsp_t;

	typedef struct packed {
		phase_t phase;
		op_t op;
		logic [23:0] instr;
		logic [23:0] effective_memory_address;
		logic [1:0] final_idx;
		logic [5:0][23:0] gpr;
		logic [3:0] cond;
		mem_req_t mem;
		logic [31:0] prdata;
		logic slverr;
	} unit_state_t;
endpackage

// *** tb/mem_model.sv ***
// word memory behind the unit's memory port
`timescale 1ns/100ps
`default_nettype none
module mem_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire shift_transfer_pkg::mem_req_t mem_out,
	input wire logic [2:0] wait_n,
	output shift_transfer_pkg::mem_rsp_t mem_in
);
	import shift_transfer_pkg::*;
	logic [23:0] mem [0:255];
	logic [23:0] rd;
	logic ack;
	logic [2:0] cnt;
	// inverted outside ack so a late sample never matches
	assign mem_in = {ack, ack ? rd : ~rd};
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ack <= 1'b0;
			cnt <= 3'd0;
			rd <= 24'h0;
		end
		else if (ack)
		begin
			ack <= 1'b0;
			cnt <= 3'd0;
		end
		else if (mem_out.req && cnt >= wait_n)
		begin
			ack <= 1'b1;
			rd <= mem[mem_out.addr[7:0]];
			if (mem_out.we)
				mem[mem_out.addr[7:0]] <= mem_out.wdata;
		end
		else if (mem_out.req)
			cnt <= cnt + 3'd1;
	end
endmodule
`default_nettype wire

// *** tb/shift_transfer_sva.sv ***
// port assertions of the shift and transfer unit
`timescale 1ns/100ps
`default_nettype none
module shift_transfer_sva
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire shift_transfer_pkg::mem_req_t mem_out,
	input wire shift_transfer_pkg::mem_rsp_t mem_in,
	input wire logic busy
);
	import shift_transfer_pkg::*;
	logic acc;
	logic cmd;
	assign acc = psel && penable;
	assign cmd = acc && pwrite && paddr == 8'h00 && !busy;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	no_wait_a: assert property (acc |-> pready) else $error("pready low");
	bad_addr_a: assert property (acc && (paddr > 8'h2c || paddr[1:0] != 2'b00) |-> pslverr
		&& (pwrite || prdata == 32'h0)) else $error("unmapped access");
	good_addr_a: assert property (acc && paddr <= 8'h2c && paddr[1:0] == 2'b00 |-> !pslverr
		&& (pwrite || prdata[31:24] == 8'h00)) else $error("mapped access");
	cmd_busy_a: assert property (cmd && pwdata[3:0] inside {[4'h1:4'hb]} |=> busy) else $error("no busy");
	reg_op_a: assert property (cmd && pwdata[3:0] inside {4'h1, 4'h2, 4'h3, 4'h8} |=> busy ##1 !busy)
		else $error("register op length");
	read_first_a: assert property (cmd && pwdata[3:0] inside {4'h4, 4'h6, 4'h7, 4'ha, 4'hb}
		|=> ##1 mem_out.req && !mem_out.we) else $error("no read first");
	req_hold_a: assert property (mem_out.req && !mem_in.ack |=> mem_out.req && $stable(mem_out))
		else $error("request moved");
	idle_req_a: assert property (!busy |-> !mem_out.req) else $error("request while idle");
	next_word_a: assert property (mem_out.req && !mem_out.we && mem_in.ack |=> !mem_out.req
		|| mem_out.we || mem_out.addr == $past(mem_out.addr) + 24'h1) else $error("second read");
endmodule
bind shift_transfer_exec_unit shift_transfer_sva shift_transfer_sva_i
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.mem_out(mem_out), .mem_in(mem_in), .busy(busy)
);
`default_nettype wire

// *** tb/test_shift_transfer_exec_unit.sv ***
// self-checking bench of the shift and transfer unit
`include "shift_transfer_defs.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, sn) begin num_checks++; if ((sn) !== (ex)) begin n_errors++; $display("[ERR] %s exp %h got %h", nm, ex, sn); end end
module test_shift_transfer_exec_unit;
	import shift_transfer_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic perr;
	logic [2:0] wait_n = 3'd0;
	mem_req_t mem_out;
	mem_rsp_t mem_in;
	logic busy;
	int n_errors = 0;
	int num_checks = 0;
	always #25 pclk = ~pclk;
	shift_transfer_exec_unit shift_transfer_exec_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mem_out(mem_out), .mem_in(mem_in), .busy(busy));
	mem_model mem_model_i (.pclk(pclk), .presetn(presetn), .mem_out(mem_out), .wait_n(wait_n),
		.mem_in(mem_in));
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		logic [31:0] r;
		apb(1'b1, a, {8'h00, d}, r);
	endtask
	task automatic chk(input string nm, input logic [7:0] a, input logic [23:0] ex);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		`CHK(nm, {8'h00, ex}, r)
	endtask
	function automatic logic [7:0] ga(input logic [2:0] k);
		return `OFF_GPR_BASE + {3'b000, k, 2'b00};
	endfunction
	function automatic logic [23:0] cf(input logic ng, input logic zr);
		return {20'h0, !ng && !zr, zr, ng, 1'b0};
	endfunction
	// polls busy at most 40 times; a hang fails the status check
	task automatic run(input op_t op);
		logic [31:0] r;
		wr(`OFF_CMD, 24'(op));
		r = 32'h1;
		for (int i = 0; i < 40 && r[0] !== 1'b0; i++) apb(1'b0, `OFF_STATUS, 32'h0, r);
		`CHK("status", 1'b0, r[0])
	endtask
	task automatic s_reset;
		for (int k = 0; k < `GPR_COUNT; k++) chk("gpr", ga(3'(k)), 24'h0);
		chk("cond", `OFF_COND, 24'h0);
		chk("hole", 8'h30, 24'h0);
		`CHK("slverr", 1'b1, perr)
		chk("odd", 8'h05, 24'h0);
		`CHK("slverr", 1'b1, perr)
	endtask
	task automatic s_shift(input op_t op, input logic [7:0] n);
		logic [47:0] d;
		d = {24'h812345, 24'h00f00f};
		wr(ga(`GPR_E), d[47:24]);
		wr(ga(`GPR_A), d[23:0]);
		wr(`OFF_INSTR, {16'h0a00, n});
		run(op);
		for (int i = 0; i < n; i++)
			if (op == OP_LOGICAL_DOUBLE_RIGHT_SHIFT) d = d >> 1;
			else if (op == OP_SINGLE_RIGHT_ROTATE) d[23:0] = {d[0], d[23:1]};
			else d = {d[0], d[47:25], d[24], d[23:1]};
		chk("e", ga(`GPR_E), d[47:24]);
		chk("a", ga(`GPR_A), d[23:0]);
		if (op == OP_SINGLE_RIGHT_ROTATE) chk("cond", `OFF_COND, cf(d[23], d[23:0] == 0));
		else chk("cond", `OFF_COND, cf(d[47], d == 0));
	endtask
	task automatic s_regswap;
		wr(ga(`GPR_I), 24'h000011);
		wr(ga(`GPR_J), 24'h800100);
		wr(ga(`GPR_K), 24'h000200);
		wr(`OFF_INSTR, 24'h000046);
		run(OP_REGISTER_SWAP);
		chk("i", ga(`GPR_I), 24'h800300);
		chk("j", ga(`GPR_J), 24'h000011);
		chk("k", ga(`GPR_K), 24'h000011);
		chk("cond", `OFF_COND, cf(1'b0, 1'b0));
		chk("odd", 8'h19, 24'h0);
		`CHK("slverr", 1'b1, perr)
	endtask
	task automatic s_swap(input op_t op, input logic [2:0] k, input logic [1:0] x, input logic [23:0] m);
		wait_n <= 3'd3;
		mem_model_i.mem[8'h40] = m;
		wr(ga(k), 24'h123456);
		wr(`OFF_EMA, 24'h000040); // plain address, never indexed
		wr(`OFF_INSTR, {10'h0, x, 12'h0});
		run(op);
		chk("reg", ga(k), m);
		chk("cond", `OFF_COND, cf(m[23], m == 0));
		`CHK("mem", 24'h123456, mem_model_i.mem[8'h40])
	endtask
	// index field 0 does nothing; register writes during a run are dropped
	task automatic s_refuse;
		logic [31:0] r;
		wait_n <= 3'd3;
		mem_model_i.mem[8'h40] = 24'h000007;
		wr(ga(`GPR_T), 24'h000077);
		wr(`OFF_INSTR, 24'h000000);
		run(OP_MEMORY_INDEX_SWAP);
		`CHK("mem", 24'h000007, mem_model_i.mem[8'h40])
		chk("k", ga(`GPR_K), 24'h000005);
		wr(`OFF_CMD, 24'(OP_MEMORY_ACCUMULATOR_SWAP));
		wr(ga(`GPR_T), 24'h000066);
		apb(1'b0, `OFF_STATUS, 32'h0, r);
		`CHK("busy", 1'b1, r[0])
		run(OP_NONE);
		chk("t", ga(`GPR_T), 24'h000077);
		chk("a", ga(`GPR_A), 24'h000007);
		`CHK("mem", 24'hc00000, mem_model_i.mem[8'h40])
	endtask
	task automatic s_extract;
		logic [7:0] b;
		wait_n <= 3'd0;
		mem_model_i.mem[8'h42] = 24'hc35a81;
		wr(ga(`GPR_A), 24'habcd00);
		wr(ga(`GPR_K), 24'h000010);
		wr(`OFF_EMA, 24'h000002);
		wr(`OFF_FINAL_IDX, 24'h3);
		for (int c = 0; c < 4; c++)
		begin
			wr(ga(`GPR_J), {2'(c), 6'h03, 16'h0030});
			run(OP_BYTE_EXTRACT);
			b = c == 1 ? 8'hc3 : c == 2 ? 8'h5a : 8'h81;
			chk("a", ga(`GPR_A), {16'habcd, b});
			chk("cond", `OFF_COND, cf(b[7], 1'b0));
			chk("j", ga(`GPR_J), {2'(c), 6'h03, 16'h0030});
		end
	endtask
	task automatic s_loads;
		wait_n <= 3'd2;
		mem_model_i.mem[8'h80] = 24'h5a5aff;
		mem_model_i.mem[8'h90] = 24'h000000;
		mem_model_i.mem[8'h91] = 24'h000001;
		wr(ga(`GPR_A), 24'h123400);
		wr(`OFF_EMA, 24'h000080);
		run(OP_MEMORY_TO_BYTE_LOAD);
		chk("a", ga(`GPR_A), 24'h1234ff);
		chk("cond", `OFF_COND, cf(1'b1, 1'b0));
		wr(`OFF_EMA, 24'h000090);
		run(OP_MEMORY_TO_DOUBLE_LOAD);
		chk("e", ga(`GPR_E), 24'h0);
		chk("a", ga(`GPR_A), 24'h1);
		chk("cond", `OFF_COND, cf(1'b0, 1'b0));
	endtask
	// overflow flag preset to 1 must survive every lane code
	task automatic s_replace;
		logic [23:0] w;
		wait_n <= 3'd1;
		wr(ga(`GPR_A), 24'h0000ee);
		wr(ga(`GPR_J), 24'h000010);
		wr(`OFF_EMA, 24'h000060);
		wr(`OFF_FINAL_IDX, 24'h2);
		for (int c = 0; c < 4; c++)
		begin
			mem_model_i.mem[8'h75] = 24'h112233;
			wr(ga(`GPR_I), {2'(c), 6'h0, 16'h0005});
			wr(`OFF_COND, 24'h1);
			run(OP_BYTE_REPLACE);
			w = c == 1 ? 24'hee2233 : c == 2 ? 24'h11ee33 : c == 3 ? 24'h1122ee : 24'h112233;
			`CHK("mem", w, mem_model_i.mem[8'h75])
			chk("cond", `OFF_COND, c == 0 ? 24'h1 : cf(w[23], 1'b0) | 24'h1);
			chk("i", ga(`GPR_I), {2'(c), 6'h0, 16'h0005});
			chk("b", ga(`GPR_A), 24'h0000ee);
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		s_reset();
		s_shift(OP_LOGICAL_DOUBLE_RIGHT_SHIFT, 8'h04);
		s_shift(OP_LOGICAL_DOUBLE_RIGHT_SHIFT, 8'hff);
		s_shift(OP_SINGLE_RIGHT_ROTATE, 8'h19);
		s_shift(OP_DOUBLE_RIGHT_ROTATE, 8'h33);
		s_regswap();
		s_swap(OP_MEMORY_ACCUMULATOR_SWAP, `GPR_A, 2'd0, 24'hc00000);
		s_swap(OP_MEMORY_EXTENSION_SWAP, `GPR_E, 2'd0, 24'h000000);
		for (int x = 1; x < 4; x++) s_swap(OP_MEMORY_INDEX_SWAP, 3'(x - 1), 2'(x), 24'h000005);
		s_refuse();
		s_extract();
		s_loads();
		s_replace();
		test_done();
	end
	initial
	begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		test_done();
	end
endmodule
`default_nettype wire
